/* common/tagger_pkg.sv */
package tagger_pkg;

   // Stream and time-tag geometry
   localparam int STREAMS      = 32;
   localparam int SEC_W        = 32;
   localparam int SUBSEC_W     = 27;
   localparam int RATE_SEL_W   = 3;
   localparam int COUNT_W      = 6;

   // Rate select codes: rate = 2 MHz shifted left by the code
   localparam logic [2:0] RATE_2M       = 3'h0;
   localparam logic [2:0] RATE_32M      = 3'h4;
   localparam logic [2:0] RATE_128M     = 3'h6;
   localparam logic [2:0] RATE_BASE_MAX = RATE_32M;
   localparam int         BASE_RATE_HZ  = 2_000_000;
   localparam int         BASE_RATE_MHZ = 2;
   localparam int         QUANTUM_MBPS  = 1024;

   // Auxiliary serial text stream
   localparam int AUX_BYTE_W      = 8;
   localparam int AUX_BURST_MAX   = 2048;
   localparam int AUX_BURST_W     = 12;
   localparam int AUX_BAUD_DFLT   = 115200;
   localparam int CLK_FREQ_HZ     = 200_000_000;
   localparam int AUX_BIT_CYCLES  = CLK_FREQ_HZ / AUX_BAUD_DFLT;
   localparam int AUX_CNT_W       = 16;

   // Tick source select
   localparam logic TICK_PRIMARY   = 1'b0;
   localparam logic TICK_ALTERNATE = 1'b1;

   // One tagged parallel sample
   typedef struct packed {
      logic [STREAMS-1:0]  bits;
      logic                validity;
      logic                top_of_second;
      logic [SEC_W-1:0]    seconds;
      logic [SUBSEC_W-1:0] subsec;
   } sample_t;

   // Last sub-second count for a link clock rate code
   function automatic logic [SUBSEC_W-1:0] sec_last(input logic [2:0] sel);
      int v;
      v = (BASE_RATE_HZ << sel) - 1;
      return v[SUBSEC_W-1:0];
   endfunction

   // Number of set bits in the active mask
   function automatic logic [COUNT_W-1:0] ones(input logic [STREAMS-1:0] m);
      logic [COUNT_W-1:0] c;
      c = '0;
      for (int k = 0; k < STREAMS; k++) begin
         c = c + COUNT_W'(m[k]);
      end
      return c;
   endfunction

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
// Two flip-flop synchroniser; first stage feeds only the second
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;

   // Both stages reset to zero
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= '0;
         sync_o   <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule // pin_sync

/* rtl/bit_stream_input_time_tagger.sv */
`timescale 1ns/10ps
// Operation
// RULE1: All streams sampled at one common rate of 2 to 32 MHz.
// RULE2: Active set must hold exactly 1, 2, 4, 8, 16 or 32 streams.
// RULE3: Only active streams are forwarded; inactive inputs read as zero.
// RULE4: Aggregate active rate limited to 1.024 Gbps in base configuration.
// RULE5: Optional 64 and 128 MHz rates raise limit to 2.048/4.096 Gbps.
// RULE6: Far side supplies link clock at least the information rate; used as reference.
// RULE7: Far side drives second tick; that sample is tagged with integer second.
// RULE8: Far side aligns tick exactly with the top-of-second data sample.
// RULE9: Validity input is carried with each sample, never interpreted.
// RULE10: Serial text bytes accepted, at most 2048 between two ticks.
// RULE11: Control port both configures the block and reports its state.
// RULE12: Commands are tick-aware; arming takes effect at the next tick.
// RULE13: Replies are delivered within the interval between two adjacent ticks.
// RULE14: Alternate second tick, possibly asynchronous, may replace the primary tick.
// RULE15: Monitor pulse marks each second boundary of observe time counter.
// RULE16: One shared time tag covers every stream of each sample.
// RULE17: Armed counter loads commanded second at next selected tick.
// RULE18: Once loaded, counter counts link cycles and ignores later ticks.
// RULE19: Every sample carries the counter value at full link clock resolution.
// RULE20: On request, notify a tick and report seconds at next monitor pulse.
// RULE21: Setting picks tick source; alternate tick is synchronised first.
module bit_stream_input_time_tagger #(
   parameter int AUX_BIT_CYCLES = tagger_pkg::AUX_BIT_CYCLES
) (
   input  wire logic                             CLK_I,
   input  wire logic                             RESET_N_I,
   input  wire logic                             LINK_CLOCK_I,
   input  wire logic [tagger_pkg::STREAMS-1:0]   INPUT_BIT_STREAM_I,
   input  wire logic                             SECOND_TICK_I,
   input  wire logic                             ALTERNATE_SECOND_TICK_I,
   input  wire logic                             INPUT_VALIDITY_I,
   input  wire logic                             AUX_SERIAL_TEXT_IN_I,
   input  wire logic [2:0]                       CLOCK_RATE_SEL_I,
   input  wire logic [2:0]                       INFO_RATE_SEL_I,
   input  wire logic                             EXT_RATE_EN_I,
   input  wire logic [tagger_pkg::STREAMS-1:0]   ACTIVE_MASK_I,
   input  wire logic                             TICK_SOURCE_I,
   input  wire logic                             TRANSMIT_EN_I,
   input  wire logic                             ARM_I,
   input  wire logic [tagger_pkg::SEC_W-1:0]     LOAD_SECOND_I,
   input  wire logic                             TICK_NOTIFY_REQ_I,
   input  wire logic                             REPORT_REQ_I,
   output tagger_pkg::sample_t                   SAMPLE_O,
   output logic                                  SAMPLE_VALID_O,
   output logic                                  CONFIG_ERR_O,
   output logic                                  ARMED_O,
   output logic                                  TIME_SET_O,
   output logic                                  OBSERVE_EPOCH_MONITOR_O,
   output logic                                  TICK_NOTIFY_O,
   output logic                                  REPORT_VALID_O,
   output logic [tagger_pkg::SEC_W-1:0]          REPORT_SECONDS_O,
   output logic [tagger_pkg::AUX_BYTE_W-1:0]     AUX_BYTE_O,
   output logic                                  AUX_BYTE_VALID_O,
   output logic                                  AUX_OVERRUN_O
);
   localparam int SW = tagger_pkg::STREAMS;
   localparam int SYNC_W = SW + 5;

   // Pins from outside the clock domain pass two flops
   logic [SYNC_W-1:0] sync_out;
   logic [SW-1:0]     bits_s;
   logic              link_s, tick_s, alt_s, valid_s, aux_s;

   pin_sync #(.W(SYNC_W)) u_sync (
      .clk_i     (CLK_I),
      .reset_n_i (RESET_N_I),
      .async_i   ({LINK_CLOCK_I, SECOND_TICK_I, ALTERNATE_SECOND_TICK_I, INPUT_VALIDITY_I,
                   AUX_SERIAL_TEXT_IN_I, INPUT_BIT_STREAM_I}),
      .sync_o    (sync_out)
   );
   assign {link_s, tick_s, alt_s, valid_s, aux_s, bits_s} = sync_out;

   // Configuration check, purely combinational
   logic                             cfg_err;
   logic [tagger_pkg::COUNT_W-1:0]   n_active;
   logic [2:0]                       ratio_log2;
   always_comb begin
      int agg;
      int limit;
      agg        = 0;
      limit      = 0;
      n_active   = tagger_pkg::ones(ACTIVE_MASK_I);
      ratio_log2 = CLOCK_RATE_SEL_I - INFO_RATE_SEL_I;
      agg        = int'(n_active) * (tagger_pkg::BASE_RATE_MHZ << INFO_RATE_SEL_I);
      limit      = tagger_pkg::QUANTUM_MBPS;                               // RULE4
      if (CLOCK_RATE_SEL_I > tagger_pkg::RATE_BASE_MAX) begin
         limit = limit << (CLOCK_RATE_SEL_I - tagger_pkg::RATE_BASE_MAX);   // RULE5
      end
      cfg_err = (n_active == '0) || ((n_active & (n_active - 1'b1)) != '0)  // RULE2
             || (INFO_RATE_SEL_I > CLOCK_RATE_SEL_I)                        // RULE6
             || (CLOCK_RATE_SEL_I > tagger_pkg::RATE_128M)
             || (CLOCK_RATE_SEL_I > tagger_pkg::RATE_BASE_MAX && !EXT_RATE_EN_I) // RULE5
             || (agg > limit);                                              // RULE4
   end

   // Sampling and time counter state
   logic                              link_prev_reg, tick_prev_reg, alt_prev_reg;
   logic [6:0]                        div_reg, div_next;
   logic                              armed_reg, armed_next, set_reg, set_next;
   logic [tagger_pkg::SEC_W-1:0]      load_sec_reg, load_sec_next;
   logic [tagger_pkg::SEC_W-1:0]      seconds_reg, seconds_next;
   logic [tagger_pkg::SUBSEC_W-1:0]   subsec_reg, subsec_next;
   logic                              notify_pend_reg, notify_pend_next;
   logic                              report_pend_reg, report_pend_next;
   tagger_pkg::sample_t               sample_next;
   logic                              link_fall, tick_rise, tick_evt, sample_tick, epoch_evt;
   logic                              smp_valid_next, report_fire;
   logic [tagger_pkg::SEC_W-1:0]      report_next;

   // Data is launched on the rising link edge, so the falling edge sees it settled
   assign link_fall = link_prev_reg & ~link_s;                               // RULE6
   assign tick_rise = link_fall & tick_s & ~tick_prev_reg;                   // RULE7
   assign tick_evt  = (TICK_SOURCE_I == tagger_pkg::TICK_PRIMARY) ? tick_rise
                    : (alt_s & ~alt_prev_reg);                               // RULE14 RULE21

   // Next values: divider, arming, observe time counter, replies
   always_comb begin
      div_next         = div_reg;
      armed_next       = armed_reg;
      load_sec_next    = load_sec_reg;
      set_next         = set_reg;
      seconds_next     = seconds_reg;
      subsec_next      = subsec_reg;
      epoch_evt        = 1'b0;
      // Tick restarts the divider; at-or-past compare so a rate change never wraps
      sample_tick      = link_fall
                      && ((div_reg >= 7'((1 << ratio_log2) - 1)) || tick_rise); // RULE1
      if (link_fall) begin
         div_next = sample_tick ? 7'h00 : div_reg + 7'h01;
      end
      if (armed_reg && tick_evt) begin
         seconds_next = load_sec_reg;                                        // RULE17
         subsec_next  = '0;
         set_next     = 1'b1;
         armed_next   = 1'b0;
         epoch_evt    = 1'b1;
      end else if (link_fall && set_reg) begin
         if (subsec_reg == tagger_pkg::sec_last(CLOCK_RATE_SEL_I)) begin     // RULE18
            subsec_next  = '0;
            seconds_next = seconds_reg + 1'b1;
            epoch_evt    = 1'b1;                                             // RULE15
         end else begin
            subsec_next = subsec_reg + 1'b1;
         end
      end
      // A new arm in the load cycle re-arms: set wins over clear
      if (ARM_I) begin
         armed_next    = 1'b1;                                               // RULE12
         load_sec_next = LOAD_SECOND_I;
      end
      notify_pend_next = (notify_pend_reg && !tick_evt) || TICK_NOTIFY_REQ_I; // RULE20
      report_fire      = report_pend_reg && epoch_evt;
      report_pend_next = (report_pend_reg && !epoch_evt) || REPORT_REQ_I;
      report_next      = report_fire ? seconds_next : REPORT_SECONDS_O;
      smp_valid_next   = sample_tick && !cfg_err && TRANSMIT_EN_I && set_next; // RULE3
      sample_next               = SAMPLE_O;
      if (smp_valid_next) begin
         sample_next.bits          = bits_s & ACTIVE_MASK_I;                 // RULE3
         sample_next.validity      = valid_s;                                // RULE9
         sample_next.top_of_second = tick_rise;                              // RULE7
         sample_next.seconds       = seconds_next;                           // RULE16
         sample_next.subsec        = subsec_next;                            // RULE19
      end
   end

   // Register the sampling and time counter group
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         link_prev_reg           <= 1'b0;
         tick_prev_reg           <= 1'b0;
         alt_prev_reg            <= 1'b0;
         div_reg                 <= 7'h00;
         armed_reg               <= 1'b0;
         load_sec_reg            <= '0;
         set_reg                 <= 1'b0;
         seconds_reg             <= '0;
         subsec_reg              <= '0;
         notify_pend_reg         <= 1'b0;
         report_pend_reg         <= 1'b0;
         SAMPLE_O                <= '0;
         SAMPLE_VALID_O          <= 1'b0;
         CONFIG_ERR_O            <= 1'b0;
         OBSERVE_EPOCH_MONITOR_O <= 1'b0;
         TICK_NOTIFY_O           <= 1'b0;
         REPORT_VALID_O          <= 1'b0;
         REPORT_SECONDS_O        <= '0;
      end else begin
         link_prev_reg           <= link_s;
         tick_prev_reg           <= link_fall ? tick_s : tick_prev_reg;
         alt_prev_reg            <= alt_s;
         div_reg                 <= div_next;
         armed_reg               <= armed_next;
         load_sec_reg            <= load_sec_next;
         set_reg                 <= set_next;
         seconds_reg             <= seconds_next;
         subsec_reg              <= subsec_next;
         notify_pend_reg         <= notify_pend_next;
         report_pend_reg         <= report_pend_next;
         SAMPLE_O                <= sample_next;
         SAMPLE_VALID_O          <= smp_valid_next;
         CONFIG_ERR_O            <= cfg_err;
         OBSERVE_EPOCH_MONITOR_O <= epoch_evt;                               // RULE15
         TICK_NOTIFY_O           <= notify_pend_reg && tick_evt;             // RULE20
         REPORT_VALID_O          <= report_fire;                             // RULE13
         REPORT_SECONDS_O        <= report_next;
      end
   end
   assign ARMED_O    = armed_reg;                                            // RULE11
   assign TIME_SET_O = set_reg;

   // Auxiliary serial receiver, 8 data bits, 1 stop bit
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
   localparam logic [tagger_pkg::AUX_CNT_W-1:0] BIT_LAST  =
      tagger_pkg::AUX_CNT_W'(AUX_BIT_CYCLES - 1);
   localparam logic [tagger_pkg::AUX_CNT_W-1:0] HALF_LAST =
      tagger_pkg::AUX_CNT_W'(AUX_BIT_CYCLES / 2 - 1);
   rx_state_t                             rx_reg, rx_next;
   logic [tagger_pkg::AUX_CNT_W-1:0]      bcnt_reg, bcnt_next;
   logic [2:0]                            nbit_reg, nbit_next;
   logic [tagger_pkg::AUX_BYTE_W-1:0]     shift_reg, shift_next;
   logic [tagger_pkg::AUX_BURST_W:0]      burst_reg, burst_next;
   logic                                  byte_ok, over_next;

   // Next values of the receiver; count resets at each selected tick
   always_comb begin
      rx_next    = rx_reg;
      bcnt_next  = (bcnt_reg == '0) ? '0 : bcnt_reg - 1'b1;
      nbit_next  = nbit_reg;
      shift_next = shift_reg;
      byte_ok    = 1'b0;
      unique case (rx_reg)
         RX_IDLE: begin
            if (!aux_s) begin
               rx_next   = RX_START;
               bcnt_next = HALF_LAST;
            end
         end
         RX_START: begin
            if (bcnt_reg == '0) begin
               rx_next   = aux_s ? RX_IDLE : RX_DATA;   // Glitch rejected
               bcnt_next = BIT_LAST;
               nbit_next = 3'h0;
            end
         end
         RX_DATA: begin
            if (bcnt_reg == '0) begin
               shift_next = {aux_s, shift_reg[tagger_pkg::AUX_BYTE_W-1:1]};
               nbit_next  = nbit_reg + 3'h1;
               bcnt_next  = BIT_LAST;
               if (nbit_reg == 3'h7) begin
                  rx_next = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (bcnt_reg == '0) begin
               byte_ok = aux_s;                         // Framing error drops byte
               rx_next = RX_IDLE;
            end
         end
      endcase
      burst_next = tick_evt ? '0 : burst_reg;
      if (byte_ok && burst_next <= (tagger_pkg::AUX_BURST_W + 1)'(tagger_pkg::AUX_BURST_MAX)) begin
         burst_next = burst_next + 1'b1;
      end
      // Over-long bursts are still delivered but flagged until the next tick
      over_next = (AUX_OVERRUN_O && !tick_evt)
               || (byte_ok                                                   // RULE10
                   && burst_next > (tagger_pkg::AUX_BURST_W + 1)'(tagger_pkg::AUX_BURST_MAX));
   end

   // Register the receiver group
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rx_reg           <= RX_IDLE;
         bcnt_reg         <= '0;
         nbit_reg         <= 3'h0;
         shift_reg        <= '0;
         burst_reg        <= '0;
         AUX_BYTE_O       <= '0;
         AUX_BYTE_VALID_O <= 1'b0;
         AUX_OVERRUN_O    <= 1'b0;
      end else begin
         rx_reg           <= rx_next;
         bcnt_reg         <= bcnt_next;
         nbit_reg         <= nbit_next;
         shift_reg        <= shift_next;
         burst_reg        <= burst_next;
         AUX_BYTE_O       <= byte_ok ? shift_reg : AUX_BYTE_O;               // RULE10
         AUX_BYTE_VALID_O <= byte_ok;
         AUX_OVERRUN_O    <= over_next;
      end
   end

   // Checks on the design's own behaviour
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);

   a_inactive_masked: assert property (SAMPLE_VALID_O |-> // RULE3
      (SAMPLE_O.bits & ~$past(ACTIVE_MASK_I)) == '0)
      else $error("inactive stream forwarded");
   a_err_blocks: assert property ($past(cfg_err) |-> !SAMPLE_VALID_O) // RULE4
      else $error("sample forwarded under bad configuration");
   a_sample_on_fall: assert property (SAMPLE_VALID_O |-> $past(link_fall)) // RULE1
      else $error("sample not on link clock edge");
   a_load_on_tick: assert property (armed_reg && tick_evt && !ARM_I |=> // RULE17
      seconds_reg == $past(load_sec_reg) && subsec_reg == '0 && !armed_reg
      && OBSERVE_EPOCH_MONITOR_O)
      else $error("counter not loaded at tick");
   a_ticks_ignored: assert property (!armed_reg && tick_evt && !link_fall |=> // RULE18
      $stable(seconds_reg))
      else $error("unarmed tick changed counter");
   a_second_wrap: assert property (link_fall && set_reg && !armed_reg && // RULE15
      subsec_reg == tagger_pkg::sec_last(CLOCK_RATE_SEL_I) |=> OBSERVE_EPOCH_MONITOR_O
      && subsec_reg == '0
      && seconds_reg == $past(seconds_reg) + 1'b1)
      else $error("second boundary missed");
   a_report_at_mon: assert property (REPORT_VALID_O |-> OBSERVE_EPOCH_MONITOR_O && // RULE20
      REPORT_SECONDS_O == seconds_reg)
      else $error("report not at monitor pulse");
   a_tag_current: assert property (SAMPLE_VALID_O |-> SAMPLE_O.seconds == seconds_reg && // RULE19
      SAMPLE_O.subsec == subsec_reg)
      else $error("sample tag differs from counter");
   a_validity_kept: assert property (SAMPLE_VALID_O |-> // RULE9
      SAMPLE_O.validity == $past(valid_s))
      else $error("validity not carried");
   a_alt_ignored: assert property ( // RULE21
      TICK_SOURCE_I == tagger_pkg::TICK_PRIMARY && armed_reg &&
      !link_fall && !ARM_I |=> armed_reg)
      else $error("arm lost without primary tick");
   a_aux_one_pulse: assert property (AUX_BYTE_VALID_O |=> !AUX_BYTE_VALID_O [*2]) // RULE10
      else $error("aux byte strobe too long");

   c_sample: cover property (SAMPLE_VALID_O && SAMPLE_O.top_of_second);
   c_load: cover property (armed_reg && tick_evt);
   c_report: cover property (REPORT_VALID_O);
   c_aux_byte: cover property (AUX_BYTE_VALID_O);
endmodule // bit_stream_input_time_tagger

/* testbench/acq_model.sv */
`timescale 1ns/10ps
// Acquisition side: link clock, streams launched on each rising link edge
module acq_model #(
   parameter int BIT_NS = 80
) (
   output logic        link_clock_o,
   output logic [31:0] streams_o,
   output logic        tick_o,
   output logic        validity_o,
   output logic        aux_o
);
   // Free running, since the clock accompanies the streams at all times
   initial begin
      link_clock_o = 1'b0;
      streams_o    = 32'h0;
      validity_o   = 1'b0;
      tick_o       = 1'b0;
      aux_o        = 1'b1;
      #1.25; // Keeps link edges off the system clock edges
      forever #62.5 link_clock_o = ~link_clock_o;
   end

   // Fresh data every link period, held until the next rising edge
   always @(posedge link_clock_o) begin
      streams_o  <= $urandom;
      validity_o <= 1'($urandom);
   end

   // Tick rises with the data bit it marks and lasts one link period
   task automatic send_tick;
      @(posedge link_clock_o);
      tick_o <= 1'b1;
      @(posedge link_clock_o);
      tick_o <= 1'b0;
   endtask

   // Start bit, eight data bits lowest first, stop bit; idle stays high
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++) begin
         aux_o = f[k];
         #(BIT_NS);
      end
   endtask
endmodule // acq_model

/* testbench/tb_top.sv */
`timescale 1ns/10ps
// Model drives the pins but the alternate tick, bench drives that and the control side
module tb_top;
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                link_clk, tick, valid_in, aux, s_vld, cfg_err, armed, t_set;
   logic                mon, notify, r_vld, a_vld, a_ovr;
   logic [31:0]         streams, r_sec, m, load_sec = 32'h0, exp_sec = 32'h0;
   logic [31:0]         mask = 32'h1;
   logic [2:0]          clk_sel = 3'h2, info_sel = 3'h2;
   logic                ext_en = 1'b0, src = 1'b0, tx_en = 1'b0, alt = 1'b0;
   logic                arm = 1'b0, nreq = 1'b0, rreq = 1'b0;
   logic [7:0]          a_byte, b;
   tagger_pkg::sample_t smp;
   int                  fails = 0;
   int                  tests_run = 0;
   int                  tops = 0;
   int                  sizes[8] = '{3, 0, 32, 1, 2, 4, 8, 16};

   // 200 MHz system clock
   initial begin
      forever #2.5 clk = ~clk;
   end

   acq_model #(.BIT_NS(80)) partner (.link_clock_o(link_clk), .streams_o(streams),
      .tick_o(tick), .validity_o(valid_in), .aux_o(aux));

   // Short serial bit time: 16 system cycles, matching the model's 80 ns
   bit_stream_input_time_tagger #(.AUX_BIT_CYCLES(16)) dut (
      .CLK_I(clk), .RESET_N_I(rst_n), .LINK_CLOCK_I(link_clk),
      .INPUT_BIT_STREAM_I(streams), .SECOND_TICK_I(tick), .ALTERNATE_SECOND_TICK_I(alt),
      .INPUT_VALIDITY_I(valid_in), .AUX_SERIAL_TEXT_IN_I(aux), .CLOCK_RATE_SEL_I(clk_sel),
      .INFO_RATE_SEL_I(info_sel), .EXT_RATE_EN_I(ext_en), .ACTIVE_MASK_I(mask),
      .TICK_SOURCE_I(src), .TRANSMIT_EN_I(tx_en), .ARM_I(arm), .LOAD_SECOND_I(load_sec),
      .TICK_NOTIFY_REQ_I(nreq), .REPORT_REQ_I(rreq), .SAMPLE_O(smp), .SAMPLE_VALID_O(s_vld),
      .CONFIG_ERR_O(cfg_err), .ARMED_O(armed), .TIME_SET_O(t_set),
      .OBSERVE_EPOCH_MONITOR_O(mon), .TICK_NOTIFY_O(notify), .REPORT_VALID_O(r_vld),
      .REPORT_SECONDS_O(r_sec), .AUX_BYTE_O(a_byte), .AUX_BYTE_VALID_O(a_vld),
      .AUX_OVERRUN_O(a_ovr));

   // Comparisons
   task automatic check_bit(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask

   // Verdict, reached from the end of the run or from a timeout
   task automatic print_verdict;
      $display("counts: compared %0d, mismatched %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Bounded wait for a flag, read as settled before each edge
   task automatic wait_hi(ref logic s, input int n, input string msg);
      for (int k = 0; k < n && s !== 1'b1; k++) begin
         @(posedge clk);
      end
      if (s !== 1'b1) begin
         fails++;
         $display("MISMATCH t=%0t timeout %s", $time, msg);
         print_verdict();
      end
   endtask

   // Arm with a second, asking for tick notice and a report as well
   task automatic arm_pulse(input logic [31:0] sec);
      load_sec <= sec;
      arm      <= 1'b1;
      nreq     <= 1'b1;
      rreq     <= 1'b1;
      @(posedge clk);
      arm  <= 1'b0;
      nreq <= 1'b0;
      rreq <= 1'b0;
      @(posedge clk);
      check_bit(armed, 1'b1, "armed");
   endtask

   // Load seen at the monitor pulse, with the report in the same cycle
   task automatic expect_load(input logic [31:0] sec);
      wait_hi(mon, 200, "epoch");
      check_bit(t_set & ~armed, 1'b1, "loaded");
      check_bit(r_vld, 1'b1, "report");
      check_word(r_sec, sec, "report sec");
      exp_sec = sec;
   endtask

   task automatic alt_pulse;
      alt <= 1'b1;
      repeat (4) @(posedge clk);
      alt <= 1'b0;
      @(posedge clk);
   endtask

   // Sub-second tag advances by the sample spacing; seconds hold
   task automatic check_steps(input int n);
      logic [26:0] prev;
      wait_hi(s_vld, 400, "sample");
      prev = smp.subsec;
      repeat (n) begin
         @(posedge clk);
         wait_hi(s_vld, 400, "sample");
         check_word(32'(smp.subsec - prev), 32'h1 << (clk_sel - info_sel), "step");
         check_word(smp.seconds, exp_sec, "seconds");
         prev = smp.subsec;
      end
   endtask

   // Every forwarded sample: inactive streams zero, validity carried along
   always @(posedge clk) begin
      if (s_vld === 1'b1) begin
         check_word(smp.bits, streams & mask, "bits");
         check_bit(smp.validity, valid_in, "validity");
         if (smp.top_of_second === 1'b1) begin
            tops++;
            check_word(32'(smp.subsec), 32'h0, "tick subsec");
         end
      end
   end

   // Main sequence
   initial begin
      void'($urandom(10));
      repeat (6) @(posedge clk);
      check_bit(armed | t_set | s_vld | mon, 1'b0, "reset");
      rst_n <= 1'b1;
      tx_en <= 1'b1;
      @(posedge clk);
      foreach (sizes[i]) begin
         m = 32'((64'h1 << sizes[i]) - 64'h1);
         mask <= 32'({m, m} >> $urandom_range(31));
         repeat (3) @(posedge clk);
         check_bit(cfg_err, !(sizes[i] inside {1, 2, 4, 8, 16, 32}), "mask");
      end
      info_sel <= 3'h3;
      repeat (3) @(posedge clk);
      check_bit(cfg_err, 1'b1, "info above clock");
      info_sel <= 3'h2;
      clk_sel  <= 3'h5;
      repeat (3) @(posedge clk);
      check_bit(cfg_err, 1'b1, "extension off");
      ext_en <= 1'b1;
      repeat (3) @(posedge clk);
      check_bit(cfg_err, 1'b0, "extension on");
      clk_sel <= 3'h2;
      repeat (3) @(posedge clk);
      $display("test config done");
      arm_pulse($urandom);
      fork
         partner.send_tick();
         wait_hi(notify, 200, "notify");
         expect_load(load_sec);
      join
      for (int i = 0; i < 3; i++) begin
         info_sel <= 3'(i);
         repeat (120) @(posedge clk);
         check_steps(3);
      end
      $display("test primary load done");
      src <= 1'b1;
      @(posedge clk);
      arm_pulse($urandom);
      fork
         alt_pulse();
         expect_load(load_sec);
      join
      // A later tick while not armed must leave the count running on
      fork
         alt_pulse();
         check_steps(6);
      join
      $display("test alternate load done");
      repeat (3) begin
         b = 8'($urandom);
         fork
            partner.send_byte(b);
            wait_hi(a_vld, 400, "aux byte");
         join
         check_word(32'(a_byte), 32'(b), "aux byte");
      end
      check_bit(a_ovr, 1'b0, "overrun");
      check_bit(tops > 0, 1'b1, "top of second");
      $display("test serial done");
      // Forwarding stops while transmit is off, though the counter runs on
      @(posedge clk);
      tx_en <= 1'b0;
      @(posedge clk);
      m = 32'h0;
      repeat (150) begin
         @(posedge clk);
         m = m | 32'(s_vld);
      end
      check_bit(m[0], 1'b0, "transmit off");
      $display("test transmit off done");
      print_verdict();
   end
endmodule // tb_top
